// ### smoke_regs.svh
`ifndef SMOKE_REGS_SVH
`define SMOKE_REGS_SVH
// Clock rate in kHz (40 MHz).
`define CLK_KHZ 40000
// Times in microseconds, as specified; the last three are plain counts.
`define STROBE_PERIOD_US 1670000
`define SENSE_ON_US 10000
`define ALARM_PERIOD_US 41670
`define BURST_US 500000
`define LONG_OFF_US 1500000
`define IO_DELAY_US 3000000
`define LED_ALARM_US 970000
`define LED_DIVIDE 24
`define BURSTS_PER_CYCLE 3
`define QUAL_CYCLES 2
// Derived cycle counts; the slow ones are defaults of top parameters.
`define SENSE_ON_CYC (`SENSE_ON_US * (`CLK_KHZ / 1000))
`define STROBE_CYC (`STROBE_PERIOD_US * (`CLK_KHZ / 1000))
`define ALARM_CYC (`ALARM_PERIOD_US * (`CLK_KHZ / 1000))
`define BURST_CYC (`BURST_US * (`CLK_KHZ / 1000))
`define LONG_OFF_CYC (`LONG_OFF_US * (`CLK_KHZ / 1000))
`define IO_DELAY_CYC (`IO_DELAY_US * (`CLK_KHZ / 1000))
`define LED_ALARM_CYC (`LED_ALARM_US * (`CLK_KHZ / 1000))
`endif

// ### smoke_pkg.sv
package smoke_pkg;
  typedef enum logic [3:0] {
    horn_idle = 4'h1,
    horn_on = 4'h2,
    horn_off = 4'h4,
    horn_long_off = 4'h8
  } horn_state_t;

  // Latched comparator results.
  typedef struct packed {
    logic smoke;
    logic low_batt;
  } sense_t;
endpackage : smoke_pkg

// ### smoke_alarm_sequencer.sv
// Functional notes
// - Idle: strobe every 1.67 s, sensing powered for 10 ms each strobe.
// - Every 24 strobes pulse LED and sample low battery during it.
// - Detector below threshold is smoke; hysteresis asserted while smoke holds.
// - Local smoke: strobe period becomes fast, horn enabled.
// - Horn: three 0.5 s bursts, 0.5/0.5/1.5 s silences, repeat.
// - Smoke rechecked in silences; horn stops when smoke gone.
// - During smoke, no low-battery alarm; LED pulses about once a second.
// - Local smoke drives interconnect high after 3 s.
// - Interconnect high from another unit speeds strobe at once.
// - Remote alarm needs line high rest of cycle plus two cycles.
// - Line low during qualification clears latch, no alarm.
// - LED pulses suppressed during a remote alarm.
// - Local alarm makes the device ignore the interconnect input.
// - All counters reset on power-up.
// - Test straps low at power-up: horn A follows low-battery comparator.
// - Sensing strobe stays 10 ms even under accelerated clock.
`timescale 1ns/1ps
`include "smoke_regs.svh"
module smoke_alarm_sequencer #(
  parameter int unsigned STROBE_CYC = `STROBE_CYC,
  parameter int unsigned SENSE_CYC = `SENSE_ON_CYC,
  parameter int unsigned ALARM_CYC = `ALARM_CYC,
  parameter int unsigned BURST_CYC = `BURST_CYC,
  parameter int unsigned LONG_OFF_CYC = `LONG_OFF_CYC,
  parameter int unsigned IO_DELAY_CYC = `IO_DELAY_CYC,
  parameter int unsigned LED_ALARM_CYC = `LED_ALARM_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Analog comparator results (pins, asynchronous)
  input wire logic smoke_cmp,
  input wire logic low_batt_cmp,
  // Test straps and accelerated clock
  input wire logic horn_input_a,
  input wire logic timing_cap_node,
  // Interconnect line
  input wire logic io_in,
  output logic io_out,
  output logic io_oe,
  // Outputs to analog and loads
  output logic sense_power,
  output logic hysteresis_en,
  output logic led,
  output logic horn_drive_a,
  output logic horn_drive_b
);
  localparam int CW = 27;

  // Three-stage synchronisers; a change counts once stages 2 and 3 agree.
  logic [4:0] s1, s2, s3, filt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= 5'h00;
      s2 <= 5'h00;
      s3 <= 5'h00;
    end else begin
      s1 <= {timing_cap_node, horn_input_a, io_in, low_batt_cmp, smoke_cmp};
      s2 <= s1;
      s3 <= s2;
    end
  end
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_filt
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) filt[g] <= 1'b0;
        else if (s2[g] == s3[g]) filt[g] <= s3[g];
      end
    end
  endgenerate
  wire smoke_raw = filt[0];
  wire batt_raw = filt[1];
  wire line_in = filt[2];
  wire strap_a = filt[3];
  wire cap_in = filt[4];

  // Straps are caught a few cycles after reset release.
  logic [2:0] boot_cnt;
  logic test_mode, accel, cap_d;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      boot_cnt <= 3'h0;
      test_mode <= 1'b0;
      accel <= 1'b0;
      cap_d <= 1'b0;
    end else begin
      cap_d <= cap_in;
      if (boot_cnt != 3'h7) boot_cnt <= boot_cnt + 3'h1;
      if (boot_cnt == 3'h6) test_mode <= !strap_a && !cap_in;
      // Any edge on the timing node marks accelerated test clocking.
      // Edges are watched only once the synchronisers have settled, so a
      // high strap level is not taken for a test clock edge after reset.
      if (boot_cnt == 3'h7 && cap_in != cap_d) accel <= 1'b1;
    end
  end

  logic local_alarm, remote_alarm, remote_fast;
  logic [CW-1:0] period_cnt;
  logic strobe;
  wire fast = local_alarm || remote_alarm || remote_fast;
  wire [CW-1:0] period_max =
    fast ? CW'(ALARM_CYC - 1) : CW'(STROBE_CYC - 1);

  // Strobe oscillator; a rising edge on the timing node replaces it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      period_cnt <= '0;
      strobe <= 1'b0;
    end else if (accel) begin
      strobe <= cap_in && !cap_d;
      period_cnt <= '0;
    end else if (period_cnt >= period_max) begin
      period_cnt <= '0;
      strobe <= 1'b1;
    end else begin
      period_cnt <= period_cnt + CW'(1);
      strobe <= 1'b0;
    end
  end

  // Sensing window is timed on clk, so acceleration cannot shorten it.
  logic [CW-1:0] sense_cnt;
  smoke_pkg::sense_t sensed;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sense_cnt <= '0;
      sense_power <= 1'b0;
      sensed <= '0;
    end else if (strobe && !sense_power) begin
      sense_power <= 1'b1;
      sense_cnt <= '0;
    end else if (sense_power) begin
      if (sense_cnt == CW'(SENSE_CYC - 1)) begin
        sense_power <= 1'b0;
        sensed.smoke <= smoke_raw;
        if (led) sensed.low_batt <= batt_raw;
      end else begin
        sense_cnt <= sense_cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) hysteresis_en <= 1'b0;
    else hysteresis_en <= sensed.smoke;
  end

  // Horn temporal pattern.
  smoke_pkg::horn_state_t hstate;
  logic [CW-1:0] horn_cnt;
  logic [1:0] burst_no;
  wire alarm_any = sensed.smoke || remote_alarm;
  // Low-battery chirp rides on the standby LED pulse; any alarm mutes it.
  wire chirp = led && sensed.low_batt && !alarm_any;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hstate <= smoke_pkg::horn_idle;
      horn_cnt <= '0;
      burst_no <= 2'h0;
    end else begin
      case (hstate)
        smoke_pkg::horn_idle: begin
          horn_cnt <= '0;
          burst_no <= 2'h0;
          if (alarm_any) hstate <= smoke_pkg::horn_on;
        end
        smoke_pkg::horn_on: begin
          if (horn_cnt == CW'(BURST_CYC - 1)) begin
            horn_cnt <= '0;
            if (burst_no == 2'(`BURSTS_PER_CYCLE - 1)) begin
              hstate <= smoke_pkg::horn_long_off;
              burst_no <= 2'h0;
            end else begin
              hstate <= smoke_pkg::horn_off;
              burst_no <= burst_no + 2'h1;
            end
          end else begin
            horn_cnt <= horn_cnt + CW'(1);
          end
        end
        smoke_pkg::horn_off: begin
          if (!alarm_any) begin
            hstate <= smoke_pkg::horn_idle;
          end else if (horn_cnt == CW'(BURST_CYC - 1)) begin
            horn_cnt <= '0;
            hstate <= smoke_pkg::horn_on;
          end else begin
            horn_cnt <= horn_cnt + CW'(1);
          end
        end
        smoke_pkg::horn_long_off: begin
          if (!alarm_any) begin
            hstate <= smoke_pkg::horn_idle;
          end else if (horn_cnt == CW'(LONG_OFF_CYC - 1)) begin
            horn_cnt <= '0;
            hstate <= smoke_pkg::horn_on;
          end else begin
            horn_cnt <= horn_cnt + CW'(1);
          end
        end
        default: hstate <= smoke_pkg::horn_idle;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      horn_drive_a <= 1'b0;
      horn_drive_b <= 1'b0;
    end else if (test_mode) begin
      horn_drive_a <= batt_raw;
      horn_drive_b <= 1'b0;
    end else begin
      horn_drive_a <= hstate == smoke_pkg::horn_on || chirp;
      horn_drive_b <= !(hstate == smoke_pkg::horn_on || chirp);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) local_alarm <= 1'b0;
    else local_alarm <= sensed.smoke;
  end

  // Interconnect drive after 3 s of local smoke.
  logic [CW-1:0] io_cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      io_cnt <= '0;
      io_out <= 1'b0;
      io_oe <= 1'b0;
    end else if (!sensed.smoke) begin
      io_cnt <= '0;
      io_out <= 1'b0;
      io_oe <= 1'b0;
    end else if (io_cnt == CW'(IO_DELAY_CYC - 1)) begin
      io_out <= 1'b1;
      io_oe <= 1'b1;
    end else begin
      io_cnt <= io_cnt + CW'(1);
    end
  end

  // Remote qualification: rest of the fast cycle plus two more strobes.
  logic [1:0] qual_cnt;
  wire line_ok = line_in && !sensed.smoke && !io_oe;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      remote_fast <= 1'b0;
      qual_cnt <= 2'h0;
      remote_alarm <= 1'b0;
    end else if (!line_ok) begin
      remote_fast <= 1'b0;
      qual_cnt <= 2'h0;
      remote_alarm <= 1'b0;
    end else begin
      remote_fast <= 1'b1;
      if (strobe && !remote_alarm) begin
        if (qual_cnt == 2'(`QUAL_CYCLES)) remote_alarm <= 1'b1;
        else qual_cnt <= qual_cnt + 2'h1;
      end
    end
  end

  // LED scheduling.
  logic [4:0] led_div;
  logic [CW-1:0] led_cnt;
  logic led_req;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      led_div <= 5'h00;
      led_cnt <= '0;
      led_req <= 1'b0;
    end else begin
      led_req <= 1'b0;
      if (sensed.smoke) begin
        led_div <= 5'h00;
        if (led_cnt >= CW'(LED_ALARM_CYC - 1)) begin
          led_cnt <= '0;
          led_req <= 1'b1;
        end else begin
          led_cnt <= led_cnt + CW'(1);
        end
      end else if (strobe) begin
        led_cnt <= '0;
        if (led_div == 5'(`LED_DIVIDE - 1)) begin
          led_div <= 5'h00;
          led_req <= 1'b1;
        end else begin
          led_div <= led_div + 5'h01;
        end
      end
    end
  end

  logic [CW-1:0] led_on_cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      led <= 1'b0;
      led_on_cnt <= '0;
    end else if (led_req && !(remote_alarm && !sensed.smoke)) begin
      led <= 1'b1;
      led_on_cnt <= '0;
    end else if (led) begin
      if (led_on_cnt == CW'(SENSE_CYC - 1)) led <= 1'b0;
      else led_on_cnt <= led_on_cnt + CW'(1);
    end
  end
endmodule : smoke_alarm_sequencer

// ### smoke_alarm_sequencer_assertions.sv
`timescale 1ns/1ps
module smoke_alarm_sequencer_checker #(
  parameter int unsigned STROBE_CYC = 200,
  parameter int unsigned SENSE_CYC = 10,
  parameter int unsigned BURST_CYC = 50,
  parameter int unsigned IO_DELAY_CYC = 300
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Watched outputs
  input wire logic io_out,
  input wire logic io_oe,
  input wire logic sense_power,
  input wire logic hysteresis_en,
  input wire logic led,
  input wire logic horn_drive_a,
  input wire logic horn_drive_b
);
  int unsigned s_run, gap, l_run, h_run, x_run;
  // Run lengths are counted so the long figures need no repetition.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_run <= 0;
      gap <= 0;
      l_run <= 0;
      h_run <= 0;
      x_run <= 0;
    end else begin
      s_run <= sense_power ? s_run + 1 : 0;
      gap <= $rose(sense_power) ? 0 : gap + 1;
      l_run <= led ? l_run + 1 : 0;
      h_run <= horn_drive_a ? h_run + 1 : 0;
      x_run <= hysteresis_en ? x_run + 1 : 0;
    end
  end
  sense_len_a: assert property (@(posedge clk) disable iff (!resetn)
    $fell(sense_power) |-> s_run == SENSE_CYC)
    else $error("sense strobe length wrong");
  strobe_gap_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(sense_power) |-> gap <= STROBE_CYC + 4)
    else $error("strobe period too long");
  led_len_a: assert property (@(posedge clk) disable iff (!resetn)
    $fell(led) |-> l_run == SENSE_CYC)
    else $error("led pulse length wrong");
  hyst_latch_a: assert property (@(posedge clk) disable iff (!resetn)
    $changed(hysteresis_en) |-> $past(sense_power) ||
      $past(sense_power, 2) || $past(sense_power, 3) || $past(sense_power, 4))
    else $error("smoke result changed outside strobe end");
  horn_excl_a: assert property (@(posedge clk) disable iff (!resetn)
    !(horn_drive_a && horn_drive_b))
    else $error("both horn drives high");
  burst_len_a: assert property (@(posedge clk) disable iff (!resetn)
    $fell(horn_drive_a) |-> h_run <= BURST_CYC + 1)
    else $error("horn burst too long");
  io_pair_a: assert property (@(posedge clk) disable iff (!resetn)
    io_oe |-> io_out)
    else $error("line enabled without driving high");
  io_delay_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(io_oe) |-> x_run + 4 >= IO_DELAY_CYC)
    else $error("line driven before the delay");
endmodule : smoke_alarm_sequencer_checker
bind smoke_alarm_sequencer smoke_alarm_sequencer_checker #(
  .STROBE_CYC(STROBE_CYC), .SENSE_CYC(SENSE_CYC), .BURST_CYC(BURST_CYC),
  .IO_DELAY_CYC(IO_DELAY_CYC)
) u_checker (.clk(clk), .resetn(resetn), .io_out(io_out), .io_oe(io_oe),
  .sense_power(sense_power), .hysteresis_en(hysteresis_en), .led(led),
  .horn_drive_a(horn_drive_a), .horn_drive_b(horn_drive_b));

// ### remote_unit_model.sv
`timescale 1ns/1ps
module remote_unit_model (
  // Clock
  input wire logic clk,
  // Interconnect line
  input wire logic io_out,
  input wire logic io_oe,
  output logic io_line
);
  logic drive_hi = 1'b0;
  // The line has a pull-down, so it falls to 0 when nobody drives it.
  assign io_line = (io_oe & io_out) | drive_hi;
  // A short hold is a deliberate glitch below the qualification span.
  task automatic send_alarm(input int n);
    @(negedge clk) drive_hi = 1'b1;
    repeat (n) @(negedge clk);
    drive_hi = 1'b0;
  endtask : send_alarm
endmodule : remote_unit_model

// ### smoke_alarm_sequencer_bench.sv
`timescale 1ns/1ps
module smoke_alarm_sequencer_bench;
  localparam int ST = 200, SC = 10, AC = 40, BC = 50, LO = 150;
  logic clk = 0, resetn = 0, smoke_cmp = 0, low_batt_cmp = 0;
  logic horn_input_a = 1, timing_cap_node = 1;
  logic io_in, io_out, io_oe, sense_power, hysteresis_en, led;
  logic horn_drive_a, horn_drive_b;
  int failures = 0, checked = 0;
  initial forever #12.5 clk = ~clk;
  smoke_alarm_sequencer #(.STROBE_CYC(ST), .SENSE_CYC(SC), .ALARM_CYC(AC),
    .BURST_CYC(BC), .LONG_OFF_CYC(LO), .IO_DELAY_CYC(300),
    .LED_ALARM_CYC(100)) u_smoke_alarm_sequencer (.clk(clk), .resetn(resetn),
    .smoke_cmp(smoke_cmp), .low_batt_cmp(low_batt_cmp),
    .horn_input_a(horn_input_a), .timing_cap_node(timing_cap_node),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .sense_power(sense_power),
    .hysteresis_en(hysteresis_en), .led(led), .horn_drive_a(horn_drive_a),
    .horn_drive_b(horn_drive_b));
  remote_unit_model u_remote_unit_model (.clk(clk), .io_out(io_out),
    .io_oe(io_oe), .io_line(io_in));
  task automatic chk(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_n(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask : chk_n
  function automatic logic pick(input int k);
    case (k)
      0: return sense_power;
      1: return led;
      2: return horn_drive_a;
      3: return hysteresis_en;
      default: return io_oe;
    endcase
  endfunction : pick
  // Bounded wait; the count tells the caller whether the limit ran out.
  task automatic wait_v(input int k, input logic v, input int lim,
      output int n);
    n = 0;
    while (pick(k) !== v && n < lim) begin
      @(posedge clk) #1;
      n++;
    end
  endtask : wait_v
  task automatic count_rises(input int k, input int cyc, output int n);
    logic prev;
    prev = pick(k);
    n = 0;
    repeat (cyc) begin
      @(posedge clk) #1;
      if (pick(k) === 1'b1 && prev !== 1'b1) n++;
      prev = pick(k);
    end
  endtask : count_rises
  // Measures one strobe: high length b and full period b + c.
  task automatic strobe(input int lim, output int b, output int c);
    int a;
    wait_v(0, 1, lim, a);
    wait_v(0, 0, lim, b);
    wait_v(0, 1, lim, c);
  endtask : strobe
  task automatic do_reset(input logic strap_a, input logic strap_c);
    @(negedge clk);
    resetn = 0;
    smoke_cmp = 0;
    low_batt_cmp = 0;
    horn_input_a = strap_a;
    timing_cap_node = strap_c;
    repeat (8) @(negedge clk);
    resetn = 1;
    @(posedge clk) #1;
    chk(sense_power | led | horn_drive_a | io_oe, 1'b0);
  endtask : do_reset
  task automatic t_idle;
    int b, c, n;
    do_reset(1, 1);
    @(negedge clk) low_batt_cmp = 1;
    strobe(ST + 20, b, c);
    chk_n(b, SC, SC);
    chk_n(b + c, ST, ST);
    chk(horn_drive_b, 1'b1);
    count_rises(1, 24 * ST, n);
    chk_n(n, 1, 1);
    // The battery level caught in one LED pulse sounds horn A through the next pulse, one cycle behind the LED.
    count_rises(2, 24 * ST, n);
    chk_n(n, 1, 1);
  endtask : t_idle
  task automatic t_smoke;
    int a, b, c;
    do_reset(1, 1);
    @(negedge clk) smoke_cmp = 1;
    wait_v(3, 1, ST + 30, a);
    chk(hysteresis_en, 1'b1);
    strobe(AC + 20, b, c);
    chk_n(b + c, AC, AC);
    chk(io_oe, 1'b0);
    wait_v(2, 1, LO + 20, a);
    chk(horn_drive_a, 1'b1);
    // The scan starts on the second burst, so the long silence comes second.
    for (int i = 0; i < 3; i++) begin
      wait_v(2, 0, BC + 5, b);
      chk_n(b, BC, BC);
      wait_v(2, 1, LO + 5, c);
      chk_n(c, i == 1 ? LO : BC, i == 1 ? LO : BC);
    end
    chk(io_oe, 1'b1);
    chk(io_in, 1'b1);
    count_rises(1, 250, a);
    chk_n(a, 2, 3);
    @(negedge clk) smoke_cmp = 0;
    wait_v(3, 0, AC + 30, a);
    chk(hysteresis_en, 1'b0);
    wait_v(2, 0, BC + 5, a);
    count_rises(2, 400, a);
    chk_n(a, 0, 0);
  endtask : t_smoke
  task automatic t_remote;
    int a;
    do_reset(1, 1);
    // The first hold spans one fast strobe and then drops.
    fork u_remote_unit_model.send_alarm(60); join_none
    wait_v(0, 1, AC + 8, a);
    chk(sense_power, 1'b1);
    count_rises(2, 300, a);
    chk_n(a, 0, 0);
    // Long enough for the LED divider to wrap while the alarm sounds.
    fork u_remote_unit_model.send_alarm(1000); join_none
    wait_v(2, 1, 200, a);
    chk(horn_drive_a, 1'b1);
    chk(io_oe, 1'b0);
    count_rises(1, 1000, a);
    chk_n(a, 0, 0);
  endtask : t_remote
  task automatic t_test;
    int a;
    do_reset(0, 0);
    repeat (12) @(negedge clk);
    low_batt_cmp = 1;
    wait_v(2, 1, 12, a);
    chk(horn_drive_a, 1'b1);
    chk(horn_drive_b, 1'b0);
    @(negedge clk) low_batt_cmp = 0;
    wait_v(2, 0, 12, a);
    chk(horn_drive_a, 1'b0);
  endtask : t_test
  task automatic t_accel;
    int b, c;
    do_reset(1, 1);
    fork
      repeat (16) begin
        repeat (30) @(negedge clk);
        timing_cap_node = ~timing_cap_node;
      end
    join_none
    strobe(ST, b, c);
    strobe(ST, b, c);
    chk_n(b, SC, SC);
    chk_n(b + c, 60, 60);
  endtask : t_accel
  task automatic tally_and_finish;
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #(25 * 30000);
    failures++;
    tally_and_finish();
  end
  initial begin
    t_idle();
    t_smoke();
    t_remote();
    t_test();
    t_accel();
    tally_and_finish();
  end
endmodule : smoke_alarm_sequencer_bench
